// ### rtl/capture_compare_timer.sv
`timescale 1ns/100ps
// Overview of operation
// - Sixteen-bit up-counter runs free or modulo, the time base for channels.
// - Modulo high and low bytes set the last count of the sequence.
// - Counter reads at any time never disturb counting.
// - Each channel independently chosen as capture or compare.
// - Capture latches counter on rising, falling or either pin edge.
// - Compare match sets, clears or toggles the channel pin.
// - Buffered and unbuffered PWM generated on the channels.
// - Seven bus clock divisions or the external clock pin drive counting.
// - Any channel pin can toggle on every counter overflow.
// - One control bit stops counting, another clears the counter.
module capture_compare_timer
    import cct_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Interrupt
    output logic             irq_o,
    // Pins
    input  wire logic        external_timer_clock_pin_i,
    input  wire logic        channel_zero_pin_i,
    input  wire logic        channel_one_pin_i,
    output logic             channel_zero_pin_o,
    output logic             channel_one_pin_o
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) r[7:0]  = new_v[7:0];
        if (sel[1]) r[15:8] = new_v[15:8];
        return r;
    endfunction : merge16

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]        ctrl_q;
    logic [15:0]       mod_q;
    logic [ST_W-1:0]   stat_q;
    logic [ST_W-1:0]   mask_q;
    logic [6:0]        cfg0_q;
    logic [6:0]        cfg1_q;
    logic [15:0]       cnt_q;
    logic [6:0]        div_q;
    logic              ack_q;
    logic [31:0]       dat_q;
    logic              irq_q;
    logic [2:0]        sync0_q;
    logic [2:0]        sync1_q;
    logic [2:0]        syncc_q;
    logic              pin0_q;
    logic              pin1_q;
    logic              tick_q;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire        req       = cyc_i & stb_i & ~ack_q;
    wire        wr        = req & we_i;
    wire        wr_ctrl   = wr & (adr_i == ADR_CTRL) & sel_i[0];
    wire        wr_mod    = wr & (adr_i == ADR_MOD);
    wire        wr_stat   = wr & (adr_i == ADR_STAT) & sel_i[0];
    wire        wr_mask   = wr & (adr_i == ADR_MASK) & sel_i[0];
    wire        wr_cfg0   = wr & (adr_i == ADR_CH0_CFG) & sel_i[0];
    wire        wr_val0   = wr & (adr_i == ADR_CH0_VAL) & (sel_i[1:0] != 2'b00);
    wire        wr_cfg1   = wr & (adr_i == ADR_CH1_CFG) & sel_i[0];
    wire        wr_val1   = wr & (adr_i == ADR_CH1_VAL) & (sel_i[1:0] != 2'b00);
    wire [15:0] val0;
    wire [15:0] val1;
    wire [15:0] val0_wr   = merge16(val0, dat_i, sel_i);
    wire [15:0] val1_wr   = merge16(val1, dat_i, sel_i);
    wire [15:0] mod_wr    = merge16(mod_q, dat_i, sel_i);
    logic [31:0] rd_data;
    always_comb begin
        unique case (adr_i)
            ADR_CTRL:    rd_data = {24'h000000, ctrl_q};
            ADR_CNT:     rd_data = {16'h0000, cnt_q};
            ADR_MOD:     rd_data = {16'h0000, mod_q};
            ADR_STAT:    rd_data = {29'h00000000, stat_q};
            ADR_MASK:    rd_data = {29'h00000000, mask_q};
            ADR_CH0_CFG: rd_data = {25'h0000000, cfg0_q};
            ADR_CH0_VAL: rd_data = {16'h0000, val0};
            ADR_CH1_CFG: rd_data = {25'h0000000, cfg1_q};
            ADR_CH1_VAL: rd_data = {16'h0000, val1};
            default:     rd_data = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // Clock source
    // ----------------------------------------
    wire [2:0] ps       = ctrl_q[CTRL_PS_LSB +: 3];
    wire       ext_rise = syncc_q[2] & ~syncc_q[1] ? 1'b0 : (syncc_q[1] & ~syncc_q[2]);
    wire [7:0] div_next = {1'b0, div_q} + 8'h01;
    wire       div_hit  = (ps == 3'h0) | ((div_next[6:0] & ((7'h01 << ps) - 7'h01)) == 7'h00);
    wire       tick_d   = (ps == PS_EXT) ? ext_rise : div_hit;
    wire       running  = ~ctrl_q[CTRL_STOP];
    wire       at_mod   = (cnt_q == mod_q);
    wire       do_tick  = tick_q & running;

    tick_if tb ();
    assign tb.tick  = do_tick;
    assign tb.count = cnt_q;
    assign tb.wrap  = at_mod;

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    wire ev0;
    wire ev1;
    wire out0;
    wire out1;
    timer_channel u_ch0 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tb       (tb),
        .cfg_i    (cfg0_q),
        .val_wr_i (val0_wr),
        .val_we_i (wr_val0),
        .pin_i    (pin0_q),
        .val_o    (val0),
        .event_o  (ev0),
        .pin_o    (out0)
    );
    timer_channel u_ch1 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tb       (tb),
        .cfg_i    (cfg1_q),
        .val_wr_i (val1_wr),
        .val_we_i (wr_val1),
        .pin_i    (pin1_q),
        .val_o    (val1),
        .event_o  (ev1),
        .pin_o    (out1)
    );

    wire [ST_W-1:0] ev_set = {ev1, ev0, do_tick & at_mod};
    wire [ST_W-1:0] stat_d = (stat_q & ~(wr_stat ? dat_i[ST_W-1:0] : {ST_W{1'b0}})) | ev_set;

    // ----------------------------------------
    // Sequential logic
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync0_q <= 3'h0;
            sync1_q <= 3'h0;
            syncc_q <= 3'h0;
            pin0_q  <= 1'b0;
            pin1_q  <= 1'b0;
        end else begin
            sync0_q <= {sync0_q[1:0], channel_zero_pin_i};
            sync1_q <= {sync1_q[1:0], channel_one_pin_i};
            syncc_q <= {syncc_q[1:0], external_timer_clock_pin_i};
            pin0_q  <= sync0_q[1];
            pin1_q  <= sync1_q[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            mod_q  <= MOD_RST;
            mask_q <= {ST_W{1'b0}};
            cfg0_q <= CFG_RST;
            cfg1_q <= CFG_RST;
            stat_q <= {ST_W{1'b0}};
        end else begin
            stat_q <= stat_d;
            if (wr_ctrl) ctrl_q <= {dat_i[7:5], 1'b0, dat_i[3:0]};
            if (wr_mod)  mod_q  <= mod_wr;
            if (wr_mask) mask_q <= dat_i[ST_W-1:0];
            if (wr_cfg0) cfg0_q <= dat_i[6:0];
            if (wr_cfg1) cfg1_q <= dat_i[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q  <= 7'h00;
            tick_q <= 1'b0;
            cnt_q  <= 16'h0000;
        end else begin
            div_q  <= div_next[6:0];
            tick_q <= tick_d;
            if (wr_ctrl & dat_i[CTRL_CLR]) begin
                cnt_q <= 16'h0000;
                div_q <= 7'h00;
            end else if (do_tick) begin
                cnt_q <= at_mod ? 16'h0000 : cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
            irq_q <= 1'b0;
            channel_zero_pin_o <= 1'b0;
            channel_one_pin_o  <= 1'b0;
        end else begin
            ack_q <= req;
            dat_q <= rd_data;
            irq_q <= |(stat_d & mask_q);
            channel_zero_pin_o <= out0;
            channel_one_pin_o  <= out1;
        end
    end
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign irq_o = irq_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        do_tick && at_mod && !(wr_ctrl && dat_i[CTRL_CLR]) |=> cnt_q == 16'h0000)
        else $error("counter did not wrap");
    a_count_up: assert property (@(posedge clk_i) disable iff (rst_i)
        do_tick && !at_mod && !wr_ctrl |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not increment");
    a_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q[CTRL_STOP] && !wr_ctrl |=> $stable(cnt_q))
        else $error("stopped counter moved");
    a_clear_cnt: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl && dat_i[CTRL_CLR] |=> cnt_q == 16'h0000)
        else $error("clear failed");
    a_clear_div: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl && dat_i[CTRL_CLR] |=> div_q == 7'h00)
        else $error("prescaler not cleared");
    a_stop_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_q[CTRL_STOP] |-> !do_tick)
        else $error("tick while stopped");
    a_ctrl_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ctrl_q[CTRL_STOP] == $past(dat_i[CTRL_STOP]))
        else $error("stop bit write lost");
    a_clr_reads0: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[CTRL_CLR])
        else $error("clear bit stored");
    a_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ps == 3'h0 |=> tick_q)
        else $error("divide by one missed tick");
    a_div_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ps != 3'h0 && ps != PS_EXT && div_next[0] |=> !tick_q)
        else $error("prescaler tick on odd count");
    a_ext_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        ps == PS_EXT && !ext_rise |=> !tick_q)
        else $error("external tick without edge");

    // ----------------------------------------
    // Bus checks
    // ----------------------------------------
    a_read_safe: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && !tick_q |=> $stable(cnt_q))
        else $error("read disturbed counter");
    a_cnt_read: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && adr_i == ADR_CNT |=> dat_o == {16'h0000, $past(cnt_q)})
        else $error("count read wrong");
    a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o ##1 !ack_o)
        else $error("ack not one cycle");
    a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !ack_o)
        else $error("ack without request");
    a_mod_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_mod && sel_i[1:0] == 2'b11 |=> mod_q == $past(dat_i[15:0]))
        else $error("modulo write lost");
    a_mod_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_mod |=> $stable(mod_q))
        else $error("modulo changed unasked");
    a_cfg0_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cfg0 |=> cfg0_q == $past(dat_i[6:0]))
        else $error("channel zero config lost");
    a_cfg1_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cfg1 |=> cfg1_q == $past(dat_i[6:0]))
        else $error("channel one config lost");

    // ----------------------------------------
    // Flag checks
    // ----------------------------------------
    a_ovf_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        do_tick && at_mod |=> stat_q[ST_OVF])
        else $error("overflow flag missing");
    a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stat && dat_i[ST_OVF] && !(do_tick && at_mod) |=> !stat_q[ST_OVF])
        else $error("overflow flag not cleared");
    a_ch0_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        ev0 |=> stat_q[ST_CH0])
        else $error("channel zero flag missing");
    a_ch1_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        ev1 |=> stat_q[ST_CH1])
        else $error("channel one flag missing");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_mask |=> irq_o == |(stat_q & mask_q))
        else $error("interrupt level wrong");

    // ----------------------------------------
    // Pin and channel value checks
    // ----------------------------------------
    a_pin0_out: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> channel_zero_pin_o == $past(out0))
        else $error("channel zero pin not registered");
    a_pin1_out: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> channel_one_pin_o == $past(out1))
        else $error("channel one pin not registered");
    a_val0_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_val0 && !cfg0_q[CFG_BUF] && !cfg0_q[CFG_MODE_LSB] |=> val0 == $past(val0_wr))
        else $error("unbuffered value not applied");
    a_buf_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_val0 && cfg0_q[CFG_BUF] && !cfg0_q[CFG_MODE_LSB] && !do_tick |=> $stable(val0))
        else $error("buffered value applied early");
    c_wrap: cover property (@(posedge clk_i) do_tick && at_mod);
    c_cap0: cover property (@(posedge clk_i) ev0 && cfg0_q[CFG_MODE_LSB]);
    c_cmp1: cover property (@(posedge clk_i) ev1 && !cfg1_q[CFG_MODE_LSB]);
    c_irq:  cover property (@(posedge clk_i) irq_o);
    c_ext:  cover property (@(posedge clk_i) ps == PS_EXT && tick_q);
endmodule : capture_compare_timer

// ### rtl/cct_pkg.sv
package cct_pkg;
    localparam int          CNT_W        = 16;
    localparam logic [7:0]  ADR_CTRL     = 8'h00;
    localparam logic [7:0]  ADR_CNT      = 8'h04;
    localparam logic [7:0]  ADR_MOD      = 8'h08;
    localparam logic [7:0]  ADR_STAT     = 8'h0C;
    localparam logic [7:0]  ADR_MASK     = 8'h10;
    localparam logic [7:0]  ADR_CH0_CFG  = 8'h14;
    localparam logic [7:0]  ADR_CH0_VAL  = 8'h18;
    localparam logic [7:0]  ADR_CH1_CFG  = 8'h1C;
    localparam logic [7:0]  ADR_CH1_VAL  = 8'h20;
    // Control register fields
    localparam int          CTRL_PS_LSB  = 0;
    localparam int          CTRL_CLR     = 4;
    localparam int          CTRL_STOP    = 5;
    localparam logic [7:0]  CTRL_RST     = 8'h20;
    localparam logic [2:0]  PS_EXT       = 3'h7;
    // Channel config fields
    localparam int          CFG_MODE_LSB = 0;
    localparam int          CFG_EDGE_LSB = 1;
    localparam int          CFG_ACT_LSB  = 3;
    localparam int          CFG_TOV      = 5;
    localparam int          CFG_BUF      = 6;
    localparam logic [6:0]  CFG_RST      = 7'h00;
    localparam logic [15:0] MOD_RST      = 16'hFFFF;
    // Status bits
    localparam int          ST_OVF       = 0;
    localparam int          ST_CH0       = 1;
    localparam int          ST_CH1       = 2;
    localparam int          ST_W         = 3;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_ANY  = 2'b11
    } edge_sel_t;
    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } cmp_act_t;
endpackage : cct_pkg

// ### rtl/tick_if.sv
`timescale 1ns/100ps
interface tick_if;
    logic        tick;
    logic [15:0] count;
    logic        wrap;
    modport src (output tick, output count, output wrap);
    modport dst (input tick, input count, input wrap);
endinterface : tick_if

// ### rtl/timer_channel.sv
`timescale 1ns/100ps
module timer_channel
    import cct_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Time base
    tick_if.dst              tb,
    // Configuration
    input  wire logic [6:0]  cfg_i,
    input  wire logic [15:0] val_wr_i,
    input  wire logic        val_we_i,
    // Synchronised pin level
    input  wire logic        pin_i,
    // Results
    output logic [15:0]      val_o,
    output logic             event_o,
    output logic             pin_o
);
    logic        pin_q;
    logic [15:0] val_q;
    logic [15:0] pend_q;
    logic        out_q;
    logic        ev_q;
    wire         is_capture = cfg_i[CFG_MODE_LSB];
    wire edge_sel_t edge_s  = edge_sel_t'(cfg_i[CFG_EDGE_LSB +: 2]);
    wire cmp_act_t  act_s   = cmp_act_t'(cfg_i[CFG_ACT_LSB +: 2]);
    wire         rise       = pin_i & ~pin_q;
    wire         fall       = ~pin_i & pin_q;
    wire         trig       = (edge_s[0] & rise) | (edge_s[1] & fall);
    wire         match      = tb.tick & (tb.count == val_q) & ~is_capture;
    wire         ovf_tog    = tb.tick & tb.wrap & cfg_i[CFG_TOV];
    logic        out_d;
    always_comb begin
        out_d = out_q;
        if (match) begin
            unique case (act_s)
                ACT_NONE:   out_d = out_q;
                ACT_TOGGLE: out_d = ~out_q;
                ACT_CLEAR:  out_d = 1'b0;
                ACT_SET:    out_d = 1'b1;
            endcase
        end
        if (ovf_tog) begin
            out_d = ~out_d;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q  <= 1'b0;
            val_q  <= 16'h0000;
            pend_q <= 16'h0000;
            out_q  <= 1'b0;
            ev_q   <= 1'b0;
        end else begin
            pin_q <= pin_i;
            out_q <= out_d;
            ev_q  <= (is_capture & trig) | match;
            if (is_capture & trig) begin
                val_q <= tb.count;
            end else if (val_we_i & ~cfg_i[CFG_BUF]) begin
                val_q <= val_wr_i;
            end else if (cfg_i[CFG_BUF] & tb.tick & tb.wrap) begin
                val_q <= pend_q;
            end
            if (val_we_i) begin
                pend_q <= val_wr_i;
            end
        end
    end
    assign val_o   = val_q;
    assign event_o = ev_q;
    assign pin_o   = out_q;
endmodule : timer_channel

// ### sim/pin_source.sv
`timescale 1ns/100ps
module pin_source (
    // Requests from the bench
    input  wire logic clk_en_i,
    input  wire logic ch0_lvl_i,
    input  wire logic ch1_lvl_i,
    // Pins toward the timer
    output logic      ext_clk_o,
    output logic      ch0_o,
    output logic      ch1_o
);
    // ----------------
    // Clock source
    // ----------------
    // 40 ns period, a quarter of the bus rate; stands low when idle
    initial ext_clk_o = 1'b0;
    always begin
        #20;
        ext_clk_o = clk_en_i ? ~ext_clk_o : 1'b0;
    end
    // Pin used only as a timer clock, never as a keypad input
    // ----------------
    // Channel pins
    // ----------------
    assign ch0_o = ch0_lvl_i;
    assign ch1_o = ch1_lvl_i;
endmodule : pin_source

// ### sim/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    import cct_pkg::*;
    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        cyc_i  = 1'b0;
    logic        stb_i  = 1'b0;
    logic        we_i   = 1'b0;
    logic [7:0]  adr_i  = 8'h00;
    logic [31:0] dat_i  = 32'h0;
    logic        clk_en = 1'b0;
    logic        lvl0   = 1'b0;
    logic        lvl1   = 1'b0;
    logic [15:0] lfsr   = 16'hD866;
    logic [31:0] dat_o, rd, c0, c1, c2;
    logic [15:0] m;
    logic        ack_o, irq_o, ext_clk, ch0_in, ch1_in, ch0_out, ch1_out, p;
    cmp_act_t    acts [5];
    int          err_count = 0;
    int          checked   = 0;
    int          cyc_n     = 0;
    int          i, d, t0, hi;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    capture_compare_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .external_timer_clock_pin_i(ext_clk), .channel_zero_pin_i(ch0_in), .channel_one_pin_i(ch1_in),
        .channel_zero_pin_o(ch0_out), .channel_one_pin_o(ch1_out));
    pin_source i_pins (.clk_en_i(clk_en), .ch0_lvl_i(lvl0), .ch1_lvl_i(lvl1),
        .ext_clk_o(ext_clk), .ch0_o(ch0_in), .ch1_o(ch1_in));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    function automatic logic pin_after(input cmp_act_t a, input logic q);
        case (a)
            ACT_SET:    return 1'b1;
            ACT_CLEAR:  return 1'b0;
            ACT_TOGGLE: return ~q;
            default:    return q;
        endcase
    endfunction : pin_after
    function automatic logic [15:0] wrap_at(input logic [15:0] c, input int n, input logic [15:0] top);
        return 16'((int'(c) + n) % (int'(top) + 1));
    endfunction : wrap_at
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= v;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            final_report();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic final_report;
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        #200000;
        err_count++;
        final_report();
    end
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        acts = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
        wb(1'b0, 8'hFC, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        wb(1'b0, ADR_CTRL, 32'h0);
        `CHK("ctrl_rst", {24'h0, CTRL_RST}, rd)
        wb(1'b0, ADR_MOD, 32'h0);
        `CHK("mod_rst", {16'h0, MOD_RST}, rd)
        wb(1'b0, ADR_CNT, 32'h0);
        `CHK("halted", 32'h0, rd)
        for (i = 0; i < 8; i++) begin
            clk_en <= (i == 7);
            wb(1'b1, ADR_CTRL, 32'h30);
            wb(1'b0, ADR_CNT, 32'h0);
            `CHK("cleared", 32'h0, rd)
            wb(1'b1, ADR_CTRL, 32'(i));
            wb(1'b0, ADR_CNT, 32'h0);
            c0 = rd;
            t0 = cyc_n;
            repeat (200) @(posedge clk_i);
            wb(1'b0, ADR_CNT, 32'h0);
            d = (cyc_n - t0) >> ((i == 7) ? 2 : i);
            `CHK("rate", 1'b1, (rd - c0 <= d + 1) && (rd - c0 + 1 >= d))
            if (i == 0) `CHK("undisturbed", 32'(d), rd - c0)
        end
        clk_en <= 1'b0;
        lfsr = next_rand(lfsr);
        m = 16'h8 + {12'h0, lfsr[3:0]};
        wb(1'b1, ADR_CTRL, 32'h30);
        wb(1'b1, ADR_MOD, {16'h0, m});
        wb(1'b1, ADR_STAT, 32'h7);
        wb(1'b1, ADR_MASK, 32'h1);
        wb(1'b1, ADR_CTRL, 32'h0);
        wb(1'b0, ADR_CNT, 32'h0);
        for (i = 0; i < 12; i++) begin
            c0 = rd;
            t0 = cyc_n;
            wb(1'b0, ADR_CNT, 32'h0);
            `CHK("wrap", {16'h0, wrap_at(c0[15:0], cyc_n - t0, m)}, rd)
        end
        wb(1'b0, ADR_STAT, 32'h0);
        `CHK("ovf_flag", 1'b1, rd[ST_OVF])
        `CHK("irq_on", 1'b1, irq_o)
        wb(1'b1, ADR_MASK, 32'h0);
        @(negedge clk_i);
        `CHK("irq_masked", 1'b0, irq_o)
        wb(1'b1, ADR_CTRL, 32'h20);
        wb(1'b1, ADR_STAT, 32'h1);
        wb(1'b1, ADR_MASK, 32'h1);
        @(negedge clk_i);
        `CHK("irq_clear", 1'b0, irq_o)
        wb(1'b1, ADR_MOD, 32'hFFFF);
        wb(1'b1, ADR_CTRL, 32'h30);
        wb(1'b1, ADR_CTRL, 32'h0);
        for (i = 1; i < 4; i++) begin
            wb(1'b1, ADR_CH0_CFG, 32'(2 * i + 1));
            wb(1'b0, ADR_CNT, 32'h0);
            c0 = rd;
            lvl0 <= 1'b1;
            repeat (10) @(posedge clk_i);
            wb(1'b0, ADR_CNT, 32'h0);
            c1 = rd;
            wb(1'b0, ADR_CH0_VAL, 32'h0);
            `CHK("cap_rise", i != 2, rd >= c0 && rd <= c1)
            lvl0 <= 1'b0;
            repeat (10) @(posedge clk_i);
            wb(1'b0, ADR_CNT, 32'h0);
            c2 = rd;
            wb(1'b0, ADR_CH0_VAL, 32'h0);
            `CHK("cap_fall", i != 1, rd >= c1 && rd <= c2)
        end
        p = 1'b0;
        for (i = 0; i < 5; i++) begin
            lfsr = next_rand(lfsr);
            wb(1'b1, ADR_CTRL, 32'h30);
            wb(1'b1, ADR_CH1_CFG, {27'h0, acts[i], 3'h0});
            wb(1'b1, ADR_CH1_VAL, {27'h0, lfsr[4:0]} + 32'h20);
            wb(1'b1, ADR_CTRL, 32'h0);
            repeat (80) @(posedge clk_i);
            p = pin_after(acts[i], p);
            `CHK("cmp_pin", p, ch1_out)
        end
        wb(1'b1, ADR_MOD, 32'hF);
        for (i = 0; i < 2; i++) begin
            wb(1'b1, ADR_CTRL, 32'h30);
            wb(1'b1, ADR_CH0_CFG, 32'h30 | 32'(i << 6));
            wb(1'b1, ADR_CH0_VAL, 32'h5);
            wb(1'b1, ADR_CTRL, 32'h0);
            repeat (32) @(posedge clk_i);
            hi = 0;
            repeat (160) @(posedge clk_i) hi += ch0_out;
            `CHK("pwm_duty", 1'b1, hi >= 50 && hi <= 70)
        end
        final_report();
    end
endmodule : testbench
